//--- verilog/orm_regmap.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01: Extended region decoded for external accesses only
// R02: Registers take one, two or four bytes
// R03: Four-byte register LSB at base plus three
// R04: Fields justified toward the least significant byte
// R05: Bits beyond field read zero, ignore writes
// R06: Capacitor nine bits, upper seven bits zero
// R07: Counter result big-endian, MSB at 0x4008
// R08: Array index zero at 0x4040, ascending
// R09: Timer reload bytes at 0xCA and 0xCB
// R10: Direct access above 0x80 selects special registers
// R11: Reserved extended addresses read zero, writes ignored
module orm_regmap
   import orm_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [7:0] DIR_ADDR,
   input wire logic DIR_RD,
   input wire logic DIR_WR,
   input wire logic [7:0] DIR_WDATA,
   output logic [7:0] DIR_RDATA,
   output logic DIR_SEL,
   input wire logic [15:0] X_ADDR,
   input wire logic X_RD,
   input wire logic X_WR,
   input wire logic [7:0] X_WDATA,
   output logic [7:0] X_RDATA,
   output logic X_SEL,
   input wire logic [31:0] FC_RESULT,
   input wire logic [7:0] PIN_BITS,
   input wire logic NV_WR,
   input wire logic [3:0] NV_IDX,
   input wire logic [7:0] NV_WDATA,
   output logic [7:0] LPOSC_TRIM,
   output logic [8:0] AMP_CAP,
   output logic [7:0] AMP_TRIM,
   output logic [7:0] XO_CTRL,
   output logic [7:0] PORT_TEST,
   output logic [15:0] TMR_A_RELOAD,
   output logic [15:0] TMR_B_RELOAD
);

   // Pin synchroniser: stage one feeds stage two only
   logic [7:0] pin_s1_r;
   logic [7:0] pin_s2_r;

   // Extended registers held here
   logic [7:0] lposc_r;               // Low-power oscillator trim
   logic [AMP_CAP_W-1:0] amp_cap_r;   // Tuning capacitor, nine bits
   logic [7:0] amp_trim_r;            // Amplifier drive trim
   logic [7:0] xo_ctrl_r;             // Crystal oscillator control
   logic [7:0] port_test_r;           // Port test setting

   // Read return registers
   logic [7:0] x_rdata_r;   // Last extended-region read byte
   logic nv_sel_r;          // Last extended read came from the array
   logic [7:0] dir_rdata_r; // Last direct-space read byte

   // Extended region decode
   wire x_acc = X_RD | X_WR;
   wire x_in_region = (X_ADDR >= XR_FIRST) && (X_ADDR <= XR_LAST);
   wire x_rd_ok = X_RD & X_SEL;
   wire x_wr_ok = X_WR & X_SEL;
   wire hit_lposc = (X_ADDR == XR_LPOSC_TRIM);
   wire hit_fc = (X_ADDR[15:2] == XR_FREQ_COUNT[15:2]);
   wire hit_cap_msb = (X_ADDR == XR_AMP_CAP);
   wire hit_cap_lsb = (X_ADDR == (XR_AMP_CAP + 16'h0001));
   wire hit_trim = (X_ADDR == XR_AMP_TRIM);
   wire hit_xo = (X_ADDR == XR_XO_CTRL);
   wire hit_port = (X_ADDR == XR_PORT_TEST);
   wire hit_nv = (X_ADDR[15:4] == XR_NV_BASE[15:4]);

   // Counter result lane: lane 0 is the MSB, lane 3 the LSB
   wire [1:0] fc_lane = X_ADDR[1:0];
   wire [4:0] fc_shift = {XR_LSB_LANE - fc_lane, 3'b000};  // see R07
   wire [31:0] fc_shifted = FC_RESULT >> fc_shift;          // see R03
   wire [7:0] fc_byte = fc_shifted[7:0];

   // Capacitor halves: field sits at the low end, MSB byte mostly padding
   wire [7:0] cap_msb_byte = {AMP_CAP_PAD, amp_cap_r[8]};  // see R04, R06
   wire [7:0] cap_lsb_byte = amp_cap_r[7:0];

   // Read selection; any address with no register answers zero
   wire [7:0] x_rd_nxt =
      hit_lposc ? lposc_r :
      hit_fc ? fc_byte :
      hit_cap_msb ? cap_msb_byte :
      hit_cap_lsb ? cap_lsb_byte :
      hit_trim ? amp_trim_r :
      hit_xo ? xo_ctrl_r :
      hit_port ? port_test_r :
      8'h00;  // see R11

   // Direct space decode
   wire dir_acc = DIR_RD | DIR_WR;
   wire [7:0] sfr_rdata;
   wire [SFR_N*8-1:0] sfr_flat;
   wire [7:0] nv_rdata;

   orm_sfr_if sfr_bus ();

   // Only external accesses inside the window are ours
   assign X_SEL = x_acc & x_in_region;  // see R01
   // Upper half of direct space belongs to the special registers
   assign DIR_SEL = dir_acc & DIR_ADDR[7];  // see R10

   assign sfr_bus.addr = DIR_ADDR;
   assign sfr_bus.wr = DIR_WR & DIR_SEL;
   assign sfr_bus.wdata = DIR_WDATA;
   assign sfr_rdata = sfr_bus.rdata;

   orm_sfr_bank u_sfr_bank (
      .clk (REF_CLK),
      .rst_n (RST_N),
      .pin_bits (pin_s2_r),
      .bus (sfr_bus.target),
      .sfr_flat (sfr_flat)
   );

   // Array byte n at base plus n
   orm_nv_bytes u_nv_bytes (
      .clk (REF_CLK),
      .rst_n (RST_N),
      .wr_en (NV_WR),
      .wr_idx (NV_IDX),
      .wr_data (NV_WDATA),
      .rd_en (x_rd_ok & hit_nv),
      .rd_idx (X_ADDR[3:0]),  // see R08
      .rd_data (nv_rdata)
   );

   // Pins come from outside the clock domain
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_r <= BYTE_RST;
         pin_s2_r <= BYTE_RST;
      end else begin
         pin_s1_r <= PIN_BITS;
         pin_s2_r <= pin_s1_r;
      end
   end

   // One-byte extended registers
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lposc_r <= BYTE_RST;
         amp_trim_r <= BYTE_RST;
         xo_ctrl_r <= BYTE_RST;
         port_test_r <= BYTE_RST;
      end else if (x_wr_ok) begin
         if (hit_lposc) begin
            lposc_r <= X_WDATA;  // see R02
         end
         if (hit_trim) begin
            amp_trim_r <= X_WDATA;
         end
         if (hit_xo) begin
            xo_ctrl_r <= X_WDATA;
         end
         if (hit_port) begin
            port_test_r <= X_WDATA;
         end
      end
   end

   // Two-byte capacitor slot: only bit 0 of the MSB byte is stored
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         amp_cap_r <= AMP_CAP_RST;
      end else if (x_wr_ok && hit_cap_msb) begin
         amp_cap_r[8] <= X_WDATA[0];  // see R05, R06
      end else if (x_wr_ok && hit_cap_lsb) begin
         amp_cap_r[7:0] <= X_WDATA;
      end
   end

   // Extended read return; held until the next read so slow cores can sample late
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         x_rdata_r <= BYTE_RST;
         nv_sel_r <= 1'b0;
      end else if (x_rd_ok) begin
         x_rdata_r <= x_rd_nxt;
         nv_sel_r <= hit_nv;
      end
   end

   // Direct read return; only the upper half is answered here
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dir_rdata_r <= BYTE_RST;
      end else if (DIR_RD && DIR_SEL) begin
         dir_rdata_r <= sfr_rdata;
      end
   end

   // Both candidates are flops; the select is a flop too
   assign X_RDATA = nv_sel_r ? nv_rdata : x_rdata_r;
   assign DIR_RDATA = dir_rdata_r;

   assign LPOSC_TRIM = lposc_r;
   assign AMP_CAP = amp_cap_r;
   assign AMP_TRIM = amp_trim_r;
   assign XO_CTRL = xo_ctrl_r;
   assign PORT_TEST = port_test_r;
   // Reload pairs are low byte first in the table
   assign TMR_A_RELOAD = sfr_flat[SFR_IDX_TA_RL_LO*8 +: 16];  // see R09
   assign TMR_B_RELOAD = sfr_flat[SFR_IDX_TB_RL_LO*8 +: 16];

   // Checks on the decode and byte mapping
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   // Write then read of the same byte on consecutive edges, as the core may issue them
   sequence s_ta_rl_wr;
      DIR_WR && (DIR_ADDR == SFR_TMR_A_RL_LO);
   endsequence
   sequence s_ta_rl_rd;
      DIR_RD && !DIR_WR && (DIR_ADDR == SFR_TMR_A_RL_LO);
   endsequence
   sequence s_nv0_wr;
      NV_WR && (NV_IDX == 4'h0);
   endsequence
   sequence s_nv0_rd;
      X_RD && !X_WR && !NV_WR && (X_ADDR == XR_NV_BASE);
   endsequence

   region_gate_a: assert property ( // see R01
      x_acc && !x_in_region |-> !X_SEL)
      else $error("extended select outside its window");
   sfr_select_a: assert property ( // see R10
      dir_acc && (DIR_ADDR >= SFR_SPACE_BASE) |-> DIR_SEL)
      else $error("direct access above 0x80 not selected");
   fc_msb_a: assert property ( // see R07
      X_RD && (X_ADDR == XR_FREQ_COUNT) |=> X_RDATA == $past(FC_RESULT[31:24]))
      else $error("counter MSB not at base");
   fc_lsb_a: assert property ( // see R03
      X_RD && (X_ADDR == XR_FREQ_COUNT + 16'h0003) |=> X_RDATA == $past(FC_RESULT[7:0]))
      else $error("counter LSB not at base plus three");
   cap_pad_a: assert property ( // see R06
      X_RD && hit_cap_msb |=> X_RDATA[7:1] == AMP_CAP_PAD)
      else $error("capacitor upper bits not zero");
   cap_write_a: assert property ( // see R05
      x_wr_ok && hit_cap_msb |=> AMP_CAP == {$past(X_WDATA[0]), $past(AMP_CAP[7:0])})
      else $error("capacitor MSB write touched other bits");
   rsvd_read_a: assert property ( // see R11
      x_rd_ok && (X_ADDR == 16'h4003) |=> X_RDATA == 8'h00)
      else $error("reserved address read not zero");
   rsvd_write_a: assert property ( // see R11
      X_WR && (X_ADDR == 16'h4018) |=>
         $stable(LPOSC_TRIM) && $stable(AMP_CAP) && $stable(AMP_TRIM) && $stable(XO_CTRL) &&
         $stable(PORT_TEST))
      else $error("reserved write changed a register");
   reload_map_a: assert property ( // see R09
      s_ta_rl_wr ##1 s_ta_rl_rd |=> DIR_RDATA == $past(DIR_WDATA, 2))
      else $error("reload low byte not at its address");
   nv_map_a: assert property ( // see R08
      s_nv0_wr ##1 s_nv0_rd |=> X_RDATA == $past(NV_WDATA, 2))
      else $error("array byte zero not at base");

   // Low half of direct space belongs to the core, never to this map
   dir_low_a: assert property ( // see R10
      dir_acc && (DIR_ADDR < SFR_SPACE_BASE) |-> !DIR_SEL)
      else $error("direct access below 0x80 selected");
   // Extended select never strays outside its window or appears without a request
   x_window_a: assert property ( // see R01
      X_SEL |-> x_acc && (X_ADDR >= XR_FIRST) && (X_ADDR <= XR_LAST))
      else $error("extended select without an in-window request");
   // The second counter byte follows the big-endian order as well
   fc_mid_a: assert property ( // see R07
      X_RD && (X_ADDR == XR_FREQ_COUNT + 16'h0001) |=> X_RDATA == $past(FC_RESULT[23:16]))
      else $error("counter second byte out of order");
   // Low capacitor byte lands in the low eight field bits only
   cap_lsb_a: assert property ( // see R06
      x_wr_ok && hit_cap_lsb |=> AMP_CAP == {$past(AMP_CAP[8]), $past(X_WDATA)})
      else $error("capacitor LSB write misplaced");
   cap_read_a: assert property ( // see R04
      X_RD && hit_cap_lsb |=> X_RDATA == $past(AMP_CAP[7:0]))
      else $error("capacitor LSB byte not at base plus one");
   // A single-byte register takes the whole byte
   lposc_write_a: assert property ( // see R02
      x_wr_ok && hit_lposc |=> LPOSC_TRIM == $past(X_WDATA))
      else $error("oscillator trim byte not stored");
   // The long reserved stretch after the port test byte reads zero throughout
   rsvd_span_a: assert property ( // see R11
      x_rd_ok && (X_ADDR >= 16'h4018) && (X_ADDR <= 16'h403F) |=> X_RDATA == 8'h00)
      else $error("reserved stretch read not zero");
   // High reload byte reads back what the timer sees
   reload_hi_a: assert property ( // see R09
      DIR_RD && DIR_SEL && (DIR_ADDR == SFR_TMR_A_RL_HI) |=> DIR_RDATA == $past(TMR_A_RELOAD[15:8]))
      else $error("reload high byte not at its address");
   // Read bytes stand until the next taken read, like plain memory
   x_hold_a: assert property ( // see R01
      !x_rd_ok |=> $stable(X_RDATA))
      else $error("extended read byte changed without a read");
   dir_hold_a: assert property ( // see R10
      !(DIR_RD && DIR_SEL) |=> $stable(DIR_RDATA))
      else $error("direct read byte changed without a read");

endmodule : orm_regmap
`default_nettype wire

//--- verilog/orm_pkg.sv
package orm_pkg;

   // Direct space: special registers live at 0x80 and above
   localparam logic [7:0] SFR_SPACE_BASE = 8'h80;
   localparam logic [7:0] SFR_STACK_POINTER = 8'h81;
   localparam logic [7:0] SFR_CIPHER_SUBST = 8'h86;
   localparam logic [7:0] SFR_TMR_B_CTRL = 8'h91;
   localparam logic [7:0] SFR_TMR_B_RL_LO = 8'h92;
   localparam logic [7:0] SFR_TMR_B_RL_HI = 8'h93;
   localparam logic [7:0] SFR_TMR_B_CNT_LO = 8'h94;
   localparam logic [7:0] SFR_TMR_B_CNT_HI = 8'h95;
   localparam logic [7:0] SFR_PIN_READ_BITS = 8'h99;
   localparam logic [7:0] SFR_RTC_CTRL = 8'h9C;
   localparam logic [7:0] SFR_PORT_SETUP = 8'hB6;
   localparam logic [7:0] SFR_PORT_IRQ_CFG = 8'hB7;
   localparam logic [7:0] SFR_SYSTEM_GEN = 8'hBE;
   localparam logic [7:0] SFR_TMR_A_CTRL = 8'hC8;
   localparam logic [7:0] SFR_TMR_SRC_SEL = 8'hC9;
   localparam logic [7:0] SFR_TMR_A_RL_LO = 8'hCA;
   localparam logic [7:0] SFR_TMR_A_RL_HI = 8'hCB;
   localparam logic [7:0] SFR_TMR_A_CNT_LO = 8'hCC;
   localparam logic [7:0] SFR_TMR_A_CNT_HI = 8'hCD;
   localparam logic [7:0] SFR_PSW = 8'hD0;
   localparam logic [7:0] SFR_PROTECTION_CONTROL_ZERO = 8'hDA;
   localparam logic [7:0] SFR_SYSTEM_SETUP = 8'hEE;

   // Table of implemented direct registers, walked by a generate loop
   localparam int SFR_N = 21;
   localparam logic [7:0] SFR_ADDR [SFR_N] = '{
      SFR_STACK_POINTER, SFR_CIPHER_SUBST, SFR_TMR_B_CTRL, SFR_TMR_B_RL_LO,
      SFR_TMR_B_RL_HI, SFR_TMR_B_CNT_LO, SFR_TMR_B_CNT_HI, SFR_PIN_READ_BITS,
      SFR_RTC_CTRL, SFR_PORT_SETUP, SFR_PORT_IRQ_CFG, SFR_SYSTEM_GEN,
      SFR_TMR_A_CTRL, SFR_TMR_SRC_SEL, SFR_TMR_A_RL_LO, SFR_TMR_A_RL_HI,
      SFR_TMR_A_CNT_LO, SFR_TMR_A_CNT_HI, SFR_PSW, SFR_PROTECTION_CONTROL_ZERO, SFR_SYSTEM_SETUP};
   // Slots in that table: the read-only pin slot, and the reload low bytes the top reads out
   localparam int SFR_IDX_PIN_BITS = 7;
   localparam int SFR_IDX_TB_RL_LO = 3;
   localparam int SFR_IDX_TA_RL_LO = 14;

   // Extended region, external data space
   localparam logic [15:0] XR_FIRST = 16'h4002;
   localparam logic [15:0] XR_LAST = 16'h404F;
   localparam logic [15:0] XR_LPOSC_TRIM = 16'h4002;
   localparam logic [15:0] XR_FREQ_COUNT = 16'h4008;
   localparam logic [15:0] XR_AMP_CAP = 16'h400C;
   localparam logic [15:0] XR_AMP_TRIM = 16'h4012;
   localparam logic [15:0] XR_XO_CTRL = 16'h4016;
   localparam logic [15:0] XR_PORT_TEST = 16'h4017;
   localparam logic [15:0] XR_NV_BASE = 16'h4040;
   localparam logic [1:0] XR_LSB_LANE = 2'h3;
   localparam int NV_DEPTH = 16;

   // Field widths and reset values
   localparam int AMP_CAP_W = 9;
   localparam logic [6:0] AMP_CAP_PAD = 7'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [8:0] AMP_CAP_RST = 9'h000;

endpackage : orm_pkg

//--- verilog/orm_sfr_if.sv
`timescale 1ns/1ps
`default_nettype none
// Byte access into the direct register bank
interface orm_sfr_if;
   logic [7:0] addr;   // Direct address
   logic wr;           // Write strobe, already qualified by selection
   logic [7:0] wdata;  // Write byte
   logic [7:0] rdata;  // Combinational read byte
   modport ctrl (output addr, output wr, output wdata, input rdata);
   modport target (input addr, input wr, input wdata, output rdata);
endinterface : orm_sfr_if
`default_nettype wire

//--- verilog/orm_nv_bytes.sv
`timescale 1ns/1ps
`default_nettype none
// Sixteen-byte image of the nonvolatile read data, one write and one read port
module orm_nv_bytes
   import orm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   input wire logic [3:0] rd_idx,
   output logic [7:0] rd_data
);
   logic [7:0] mem_r [NV_DEPTH];  // Storage, no reset: filled by the loader
   logic [7:0] rd_data_r;         // Read register, holds between reads

   // Loader write
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_r[wr_idx] <= wr_data;
      end
   end

   // Read only when asked, so the answer stands until the next read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= BYTE_RST;
      end else if (rd_en) begin
         rd_data_r <= mem_r[rd_idx];
      end
   end

   assign rd_data = rd_data_r;
endmodule : orm_nv_bytes
`default_nettype wire

//--- verilog/orm_sfr_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Bank of direct-space byte registers, one slot per table entry
module orm_sfr_bank
   import orm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] pin_bits,
   orm_sfr_if.target bus,
   output logic [SFR_N*8-1:0] sfr_flat
);
   logic [SFR_N-1:0] hit;        // One-hot address match
   logic [7:0] slot [SFR_N];     // Value of each slot
   logic [7:0] rd_mux;           // Or of matching slot values

   genvar i;
   generate
      for (i = 0; i < SFR_N; i++) begin : g_slot
         assign hit[i] = (bus.addr == SFR_ADDR[i]);
         if (i == SFR_IDX_PIN_BITS) begin : g_ro
            // Read-only: shows the pins, writes are dropped
            assign slot[i] = pin_bits;
         end else begin : g_rw
            logic [7:0] val_r;  // Stored byte
            // Byte write on exact address match
            always_ff @(posedge clk or negedge rst_n) begin
               if (!rst_n) begin
                  val_r <= BYTE_RST;
               end else if (bus.wr && hit[i]) begin
                  val_r <= bus.wdata;
               end
            end
            assign slot[i] = val_r;
         end
         assign sfr_flat[i*8 +: 8] = slot[i];
      end
   endgenerate

   // Unoccupied addresses match nothing and read as zero
   always_comb begin
      rd_mux = 8'h00;
      for (int k = 0; k < SFR_N; k++) begin
         if (hit[k]) begin
            rd_mux = rd_mux | slot[k];
         end
      end
   end

   assign bus.rdata = rd_mux;
endmodule : orm_sfr_bank
`default_nettype wire

//--- test/orm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Model of the embedded core issuing byte accesses on both register buses
module orm_cpu_model (
   input wire logic clk,
   output logic [7:0] dir_addr,
   output logic dir_rd,
   output logic dir_wr,
   output logic [7:0] dir_wdata,
   input wire logic [7:0] dir_rdata,
   input wire logic dir_sel,
   output logic [15:0] x_addr,
   output logic x_rd,
   output logic x_wr,
   output logic [7:0] x_wdata,
   input wire logic [7:0] x_rdata,
   input wire logic x_sel
);
   // Idle bus at time zero
   initial begin
      {dir_addr, dir_rd, dir_wr, dir_wdata} = '0;
      {x_addr, x_rd, x_wr, x_wdata} = '0;
   end

   // One direct access: request held to the taking edge, then released
   task automatic dir_acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic s);
      @(posedge clk);
      dir_addr <= a;
      dir_wdata <= d;
      dir_wr <= wr;
      dir_rd <= !wr;
      @(posedge clk);
      s = dir_sel;
      dir_rd <= 1'b0;
      dir_wr <= 1'b0;
      // Released lines flip so a stale value cannot pass for a held one
      dir_addr <= ~a;
      dir_wdata <= ~d;
      // Read byte holds until the next taken read, so one spare cycle is safe
      @(posedge clk);
      #1 q = dir_rdata;
   endtask : dir_acc

   // Write then read the same byte on the next edge, the tightest legal order
   task automatic dir_wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      dir_addr <= a;
      dir_wdata <= d;
      dir_wr <= 1'b1;
      dir_rd <= 1'b0;
      @(posedge clk);
      dir_wr <= 1'b0;
      dir_rd <= 1'b1;
      @(posedge clk);
      dir_rd <= 1'b0;
      dir_addr <= ~a;
      dir_wdata <= ~d;
      #1 q = dir_rdata;
   endtask : dir_wr_rd

   // One external-data access, same handshake as the direct bus
   task automatic x_acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic s);
      @(posedge clk);
      x_addr <= a;
      x_wdata <= d;
      x_wr <= wr;
      x_rd <= !wr;
      @(posedge clk);
      s = x_sel;
      x_rd <= 1'b0;
      x_wr <= 1'b0;
      x_addr <= ~a;
      x_wdata <= ~d;
      @(posedge clk);
      #1 q = x_rdata;
   endtask : x_acc
endmodule : orm_cpu_model
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the register map decode
module tb_top;
   import orm_pkg::*;
   logic ref_clk, rst_n, dir_rd, dir_wr, dir_sel, x_rd, x_wr, x_sel, nv_wr, s;
   logic [7:0] dir_addr, dir_wdata, dir_rdata, x_wdata, x_rdata, pin_bits, nv_wdata, q;
   logic [15:0] x_addr, tmr_a_reload, tmr_b_reload;
   logic [31:0] fc_result;
   logic [3:0] nv_idx;
   logic [8:0] amp_cap;
   logic [7:0] lposc_trim, amp_trim, xo_ctrl, port_test;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   // Byte registers of the extended region and reserved holes inside it
   logic [15:0] xb [4] = '{XR_LPOSC_TRIM, XR_AMP_TRIM, XR_XO_CTRL, XR_PORT_TEST};
   logic [15:0] hole [8] = '{16'h4003, 16'h4007, 16'h400E, 16'h4011,
                             16'h4013, 16'h4015, 16'h4018, 16'h403F};

   orm_regmap orm_regmap_i (.REF_CLK(ref_clk), .RST_N(rst_n), .DIR_ADDR(dir_addr),
      .DIR_RD(dir_rd), .DIR_WR(dir_wr), .DIR_WDATA(dir_wdata), .DIR_RDATA(dir_rdata),
      .DIR_SEL(dir_sel), .X_ADDR(x_addr), .X_RD(x_rd), .X_WR(x_wr), .X_WDATA(x_wdata),
      .X_RDATA(x_rdata), .X_SEL(x_sel), .FC_RESULT(fc_result), .PIN_BITS(pin_bits),
      .NV_WR(nv_wr), .NV_IDX(nv_idx), .NV_WDATA(nv_wdata), .LPOSC_TRIM(lposc_trim),
      .AMP_CAP(amp_cap), .AMP_TRIM(amp_trim), .XO_CTRL(xo_ctrl), .PORT_TEST(port_test),
      .TMR_A_RELOAD(tmr_a_reload), .TMR_B_RELOAD(tmr_b_reload));

   orm_cpu_model orm_cpu_model_i (.clk(ref_clk), .dir_addr(dir_addr), .dir_rd(dir_rd),
      .dir_wr(dir_wr), .dir_wdata(dir_wdata), .dir_rdata(dir_rdata), .dir_sel(dir_sel),
      .x_addr(x_addr), .x_rd(x_rd), .x_wr(x_wr), .x_wdata(x_wdata), .x_rdata(x_rdata),
      .x_sel(x_sel));

   // 25 MHz reference
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Compare one value, case equality so unknowns never match
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // Short forms of the bus calls
   task automatic dwr(input logic [7:0] a, input logic [7:0] d);
      orm_cpu_model_i.dir_acc(1'b1, a, d, q, s);
   endtask : dwr
   task automatic dchk(input logic [7:0] a, input logic [7:0] exp);
      orm_cpu_model_i.dir_acc(1'b0, a, 8'h00, q, s);
      check(q, exp);
   endtask : dchk
   task automatic xwr(input logic [15:0] a, input logic [7:0] d);
      orm_cpu_model_i.x_acc(1'b1, a, d, q, s);
   endtask : xwr
   task automatic xchk(input logic [15:0] a, input logic [7:0] exp);
      orm_cpu_model_i.x_acc(1'b0, a, 8'h00, q, s);
      check(q, exp);
   endtask : xchk

   // Hang guard: about a hundred accesses need well under this many cycles
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         give_verdict();
      end
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      fc_result = 32'h0000_0000;
      pin_bits = 8'h00;
      {nv_wr, nv_idx, nv_wdata} = '0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      // Reset state
      check(tmr_a_reload, 16'h0000);
      check(amp_cap, 9'h000);
      xchk(XR_LPOSC_TRIM, BYTE_RST);
      // Every writable direct register keeps its own byte, no aliasing
      for (int i = 0; i < SFR_N; i++) begin
         if (i != SFR_IDX_PIN_BITS) dwr(SFR_ADDR[i], SFR_ADDR[i] ^ 8'h5A);
      end
      check(s, 1'b1);
      for (int i = 0; i < SFR_N; i++) begin
         if (i != SFR_IDX_PIN_BITS) dchk(SFR_ADDR[i], SFR_ADDR[i] ^ 8'h5A);
      end
      check(tmr_a_reload, {SFR_TMR_A_RL_HI ^ 8'h5A, SFR_TMR_A_RL_LO ^ 8'h5A});
      check(tmr_b_reload, {SFR_TMR_B_RL_HI ^ 8'h5A, SFR_TMR_B_RL_LO ^ 8'h5A});
      // Back-to-back write and read of the reload low byte
      orm_cpu_model_i.dir_wr_rd(SFR_TMR_A_RL_LO, 8'h3C, q);
      check(q, 8'h3C);
      check(tmr_a_reload, {SFR_TMR_A_RL_HI ^ 8'h5A, 8'h3C});
      // Below 0x80 nothing is selected; an unlisted upper slot reads zero
      orm_cpu_model_i.dir_acc(1'b1, 8'h7F, 8'hFF, q, s);
      check(s, 1'b0);
      dwr(8'hE0, 8'hFF);
      dchk(8'hE0, 8'h00);
      // An external access at a direct-space number leaves the register alone
      orm_cpu_model_i.x_acc(1'b1, 16'h0081, 8'h00, q, s);
      check(s, 1'b0);
      dchk(SFR_STACK_POINTER, SFR_STACK_POINTER ^ 8'h5A);
      // Pin bits are read only and pass the synchroniser
      pin_bits <= 8'hA5;
      repeat (3) @(posedge ref_clk);
      dwr(SFR_PIN_READ_BITS, 8'h00);
      dchk(SFR_PIN_READ_BITS, 8'hA5);
      // Extended byte registers
      for (int i = 0; i < 4; i++) xwr(xb[i], xb[i][7:0] ^ 8'hC3);
      for (int i = 0; i < 4; i++) xchk(xb[i], xb[i][7:0] ^ 8'hC3);
      check(lposc_trim, XR_LPOSC_TRIM[7:0] ^ 8'hC3);
      check(amp_trim, XR_AMP_TRIM[7:0] ^ 8'hC3);
      check(xo_ctrl, XR_XO_CTRL[7:0] ^ 8'hC3);
      check(port_test, XR_PORT_TEST[7:0] ^ 8'hC3);
      // Capacitor word: nine bits toward the low byte, upper bits stay zero
      xwr(XR_AMP_CAP, 8'hFF);
      check(s, 1'b1);
      xwr(XR_AMP_CAP + 16'h0001, 8'hAB);
      check(amp_cap, 9'h1AB);
      xchk(XR_AMP_CAP, 8'h01);
      xchk(XR_AMP_CAP + 16'h0001, 8'hAB);
      xwr(XR_AMP_CAP, 8'hFE);
      check(amp_cap, 9'h0AB);
      // Counter result big-endian, read only
      fc_result <= 32'h1234_5678;
      xwr(XR_FREQ_COUNT, 8'h00);
      for (int i = 0; i < 4; i++) begin
         xchk(XR_FREQ_COUNT + 16'(i), 8'(32'h1234_5678 >> (24 - 8 * i)));
      end
      // Reserved holes read zero and do not disturb neighbours
      for (int i = 0; i < 8; i++) xwr(hole[i], 8'hFF);
      for (int i = 0; i < 8; i++) xchk(hole[i], 8'h00);
      check(amp_cap, 9'h0AB);
      check(lposc_trim, XR_LPOSC_TRIM[7:0] ^ 8'hC3);
      // Just outside the region nothing is selected
      orm_cpu_model_i.x_acc(1'b1, XR_FIRST - 16'h0001, 8'hFF, q, s);
      check(s, 1'b0);
      orm_cpu_model_i.x_acc(1'b0, XR_LAST + 16'h0001, 8'h00, q, s);
      check(s, 1'b0);
      // Load the array image, then read it back in index order
      for (int i = 0; i < NV_DEPTH; i++) begin
         @(posedge ref_clk);
         nv_wr <= 1'b1;
         nv_idx <= 4'(i);
         nv_wdata <= {4'h9, 4'(i)};
      end
      @(posedge ref_clk);
      nv_wr <= 1'b0;
      for (int i = 0; i < NV_DEPTH; i++) xchk(XR_NV_BASE + 16'(i), {4'h9, 4'(i)});
      xwr(XR_NV_BASE + 16'h0005, 8'h00);
      xchk(XR_NV_BASE + 16'h0005, 8'h95);
      // Loader write to byte zero, read on the very next edge
      nv_wr <= 1'b1;
      nv_idx <= 4'h0;
      nv_wdata <= 8'h3C;
      fork
         orm_cpu_model_i.x_acc(1'b0, XR_NV_BASE, 8'h00, q, s);
         begin
            @(posedge ref_clk);
            nv_wr <= 1'b0;
         end
      join
      check(q, 8'h3C);
      // A second reset clears the registers again
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(tmr_a_reload, 16'h0000);
      check(amp_cap, 9'h000);
      rst_n <= 1'b1;
      dchk(SFR_TMR_A_RL_LO, BYTE_RST);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
